// [hdl/lsir_pkg.sv]
// package for the light sensor interrupt reporting block
package lsir_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_LOW_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_EVENT = 8'h18;
  // config field positions
  localparam int CFG_FAULT_LSB = 0;
  localparam int CFG_LEVEL_SEL_BIT = 3;
  localparam int CFG_LATCH_BIT = 4;
  localparam int CFG_FLAG_LOW_BIT = 5;
  localparam int CFG_FLAG_HIGH_BIT = 6;
  localparam int CFG_READY_BIT = 7;
  localparam int CFG_MODE_LSB = 9;
  // low limit mode bits position (top two bits of 16)
  localparam int LOW_MODE_LSB = 14;
  localparam logic [1:0] LOW_MODE_EOC = 2'b11;
  localparam logic [1:0] OP_SHUTDOWN = 2'b00;
  // event register bits
  localparam int EVT_CONV_BIT = 0;
  localparam int EVT_ALERT_BIT = 1;
  // reset values
  localparam logic [15:0] CONFIG_RST = 16'h0010;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'hffff;
  // interrupt status bits
  localparam int IRQ_HIGH_BIT = 0;
  localparam int IRQ_LOW_BIT = 1;
  localparam int IRQ_CONV_BIT = 2;
endpackage

// [hdl/lsir_fault_if.sv]
// interface carrying one limit comparison to a fault counter
`timescale 1ns/1ns
`default_nettype none
interface lsir_fault_if;
  logic conv;
  logic over;
  logic [1:0] count_sel;
  logic fault;
  modport ctl (output conv, output over, output count_sel, input fault);
  modport cnt (input conv, input over, input count_sel, output fault);
endinterface
`default_nettype wire

// [hdl/lsir_fault_cnt.sv]
// consecutive fault counter for one limit
`timescale 1ns/1ns
`default_nettype none
module lsir_fault_cnt (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // comparison link
  lsir_fault_if.cnt f
);
  logic [3:0] cnt_r;
  logic [3:0] need;
  logic [3:0] cnt_nxt;
  // fault count field 0..3 means 1,2,4,8 faults
  assign need = 4'h1 << f.count_sel;
  assign cnt_nxt = f.over ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
  // a streak past the target keeps firing on every further conversion
  assign f.fault = f.conv && f.over && (cnt_nxt >= need);
  // streak resets when a conversion stays within the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else if (f.conv) begin
      cnt_r <= cnt_nxt;
    end
  end

  // a passing conversion must end the streak
  streak_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    f.conv && !f.over |=> cnt_r == 4'h0)
    else $error("fault streak not reset");
endmodule // lsir_fault_cnt
`default_nettype wire

// [hdl/lsir_top.sv]
// interrupt reporting logic of an ambient light sensor, with apb registers
// Behaviour
// - low limit top bits 11b select end-of-conversion mode
// - end-of-conversion mode raises the interrupt after every measurement
// - eoc latched: high fault sets high flag, interrupt and ready
// - eoc latched: low fault sets low flag, interrupt and ready
// - eoc: conversion without fault keeps flags, raises interrupt, sets ready
// - eoc latched: config read clears flags, interrupt, ready; alert clears interrupt only
// - config write selecting shutdown keeps flags, ready and interrupt
// - non-shutdown config write clears ready; interrupt cleared in eoc, or when latched and latch bit written low (prose followed)
// - latch bit selects latched window or transparent hysteresis
// - transparent: high fault sets high, low fault sets low and drops interrupt outside eoc
// - alert response ignored while latch bit is clear
// - pin level follows polarity bit
`timescale 1ns/1ns
`default_nettype none
module lsir_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side, same clock
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic alert_resp,
  // outputs
  output logic int_pin,
  output logic irq
);
  logic [15:0] cfg_r;
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] result_r;
  logic flag_high_r, flag_low_r, ready_r, int_act_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  logic [31:0] prdata_r;
  logic int_pin_r, irq_r;
  lsir_fault_if hi_if ();
  lsir_fault_if lo_if ();

  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire cfg_rd = rd && (paddr == lsir_pkg::ADDR_CONFIG);
  wire cfg_wr = wr && (paddr == lsir_pkg::ADDR_CONFIG);
  wire low_wr = wr && (paddr == lsir_pkg::ADDR_LOW_LIMIT);
  wire high_wr = wr && (paddr == lsir_pkg::ADDR_HIGH_LIMIT);
  wire stat_wr = wr && (paddr == lsir_pkg::ADDR_IRQ_STATUS);
  wire mask_wr = wr && (paddr == lsir_pkg::ADDR_IRQ_MASK);
  wire evt_wr = wr && (paddr == lsir_pkg::ADDR_EVENT);
  wire mapped = (paddr == lsir_pkg::ADDR_CONFIG) || (paddr == lsir_pkg::ADDR_LOW_LIMIT)
    || (paddr == lsir_pkg::ADDR_HIGH_LIMIT) || (paddr == lsir_pkg::ADDR_RESULT)
    || (paddr == lsir_pkg::ADDR_IRQ_STATUS) || (paddr == lsir_pkg::ADDR_IRQ_MASK)
    || (paddr == lsir_pkg::ADDR_EVENT);

  // conversion and alert events, either from ports or from software pokes
  wire conv = conv_done || (evt_wr && pwdata[lsir_pkg::EVT_CONV_BIT]);
  wire alert = alert_resp || (evt_wr && pwdata[lsir_pkg::EVT_ALERT_BIT]);
  wire [15:0] res = conv_done ? conv_result : result_r;

  // mode decode
  wire eoc = low_r[lsir_pkg::LOW_MODE_LSB +: 2] == lsir_pkg::LOW_MODE_EOC;
  wire latch = cfg_r[lsir_pkg::CFG_LATCH_BIT];
  wire level_sel = cfg_r[lsir_pkg::CFG_LEVEL_SEL_BIT];
  wire level_sel_nxt = cfg_wr ? pwdata[lsir_pkg::CFG_LEVEL_SEL_BIT] : level_sel;
  wire [1:0] opmode = pwdata[lsir_pkg::CFG_MODE_LSB +: 2];
  wire run_wr = cfg_wr && (opmode != lsir_pkg::OP_SHUTDOWN);

  // comparisons feed the two fault counters
  assign hi_if.conv = conv;
  assign hi_if.over = res > high_r;
  assign hi_if.count_sel = cfg_r[lsir_pkg::CFG_FAULT_LSB +: 2];
  assign lo_if.conv = conv;
  assign lo_if.over = res < low_r;
  assign lo_if.count_sel = cfg_r[lsir_pkg::CFG_FAULT_LSB +: 2];
  lsir_fault_cnt u_hi (.pclk(pclk), .presetn(presetn), .f(hi_if));
  lsir_fault_cnt u_lo (.pclk(pclk), .presetn(presetn), .f(lo_if));
  wire hf = hi_if.fault;
  wire lf = lo_if.fault;

  // next flag state: events win over clears in the same cycle
  logic fh_nxt, fl_nxt, rdy_nxt, int_nxt;
  always_comb begin
    fh_nxt = flag_high_r;
    fl_nxt = flag_low_r;
    rdy_nxt = ready_r;
    int_nxt = int_act_r;
    if (latch) begin
      // latched window: clears first, then events set
      if (cfg_rd) begin
        fh_nxt = 1'b0;
        fl_nxt = 1'b0;
        int_nxt = 1'b0;
      end
      if (alert) begin
        int_nxt = 1'b0;
      end
      if (eoc && run_wr) begin
        int_nxt = 1'b0;
      end
      // after leaving eoc a run write clears the interrupt only if it writes the latch bit low
      if (!eoc && run_wr && !pwdata[lsir_pkg::CFG_LATCH_BIT]) begin
        int_nxt = 1'b0;
      end
      if (hf) begin
        fh_nxt = 1'b1;
        int_nxt = 1'b1;
      end
      if (lf) begin
        fl_nxt = 1'b1;
        int_nxt = 1'b1;
      end
    end else begin
      // transparent hysteresis: alert ignored
      if (eoc && (cfg_rd || run_wr)) begin
        int_nxt = 1'b0;
      end
      if (hf) begin
        fh_nxt = 1'b1;
        fl_nxt = 1'b0;
        int_nxt = 1'b1;
      end
      if (lf) begin
        fl_nxt = 1'b1;
        fh_nxt = 1'b0;
        int_nxt = eoc;
      end
    end
    if (cfg_rd || run_wr) begin
      rdy_nxt = 1'b0;
    end
    if (conv) begin
      rdy_nxt = 1'b1;
      if (eoc) begin
        int_nxt = 1'b1;
      end
    end
  end

  // flag state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_high_r <= 1'b0;
      flag_low_r <= 1'b0;
      ready_r <= 1'b0;
      int_act_r <= 1'b0;
    end else begin
      flag_high_r <= fh_nxt;
      flag_low_r <= fl_nxt;
      ready_r <= rdy_nxt;
      int_act_r <= int_nxt;
    end
  end

  // pin level registered so it is glitch free toward the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pin_r <= 1'b1;
    end else begin
      int_pin_r <= int_nxt ~^ level_sel_nxt;
    end
  end

  // configuration and limit registers; flag bits of config are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= lsir_pkg::CONFIG_RST;
      low_r <= lsir_pkg::LOW_RST;
      high_r <= lsir_pkg::HIGH_RST;
      result_r <= 16'h0000;
    end else begin
      if (cfg_wr) cfg_r <= pwdata[15:0];
      if (low_wr) low_r <= pwdata[15:0];
      if (high_wr) high_r <= pwdata[15:0];
      if (conv_done) result_r <= conv_result;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  wire [2:0] ev = {rdy_nxt & ~ready_r, fl_nxt & ~flag_low_r, fh_nxt & ~flag_high_r};
  wire [2:0] stat_nxt = (irq_stat_r & ~(stat_wr ? pwdata[2:0] : 3'h0)) | ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= stat_nxt;
      if (mask_wr) irq_mask_r <= pwdata[2:0];
      irq_r <= |(stat_nxt & (mask_wr ? pwdata[2:0] : irq_mask_r));
    end
  end

  // read mux, config shows live flags
  logic [15:0] cfg_view;
  always_comb begin
    cfg_view = cfg_r;
    cfg_view[lsir_pkg::CFG_FLAG_HIGH_BIT] = flag_high_r;
    cfg_view[lsir_pkg::CFG_FLAG_LOW_BIT] = flag_low_r;
    cfg_view[lsir_pkg::CFG_READY_BIT] = ready_r;
  end
  wire [31:0] rmux =
    (paddr == lsir_pkg::ADDR_CONFIG) ? {16'h0000, cfg_view} :
    (paddr == lsir_pkg::ADDR_LOW_LIMIT) ? {16'h0000, low_r} :
    (paddr == lsir_pkg::ADDR_HIGH_LIMIT) ? {16'h0000, high_r} :
    (paddr == lsir_pkg::ADDR_RESULT) ? {16'h0000, result_r} :
    (paddr == lsir_pkg::ADDR_IRQ_STATUS) ? {29'h0000_0000, irq_stat_r} :
    (paddr == lsir_pkg::ADDR_IRQ_MASK) ? {29'h0000_0000, irq_mask_r} : 32'h0000_0000;

  // apb answer: no wait state, pready registered
  logic pready_r, pslverr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) prdata_r <= rmux;
    end
  end

  // access acts only at the completing edge
  wire done = acc && pready_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign int_pin = int_pin_r;
  assign irq = irq_r;

  // checks
  eoc_conv_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    eoc && conv_done && !done |=> int_act_r && ready_r)
    else $error("eoc conversion did not raise interrupt");
  latch_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && hf |=> flag_high_r && int_act_r)
    else $error("high fault not latched");
  latch_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && lf |=> flag_low_r && int_act_r)
    else $error("low fault not latched");
  cfg_rd_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && cfg_rd && !conv && !hf && !lf |=> !flag_high_r && !flag_low_r && !ready_r)
    else $error("config read did not clear");
  alert_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && alert && !conv && !cfg_rd && !cfg_wr |=> !int_act_r && $stable(flag_high_r))
    else $error("alert response wrong");
  shutdown_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_wr && !run_wr && !conv && !alert |=> $stable(ready_r) && $stable(int_act_r))
    else $error("shutdown write changed state");
  run_wr_rdy_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_wr && !conv |=> !ready_r)
    else $error("run write kept ready");
  trans_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    !latch && !eoc && lf && !hf |=> flag_low_r && !flag_high_r && !int_act_r)
    else $error("transparent low fault wrong");
  trans_alert_a: assert property (@(posedge pclk) disable iff (!presetn)
    !latch && !eoc && alert && !hf && !lf |=> $stable(int_act_r))
    else $error("alert not ignored");
  pin_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 int_pin == (int_act_r ~^ level_sel))
    else $error("pin level wrong");
  // mode and access rules that the directed tests reach only in part
  noeoc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !eoc && conv && !hf && !lf && !done && !alert |=> $stable(int_act_r))
    else $error("plain conversion moved interrupt");
  eoc_flags_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    eoc && conv && !hf && !lf && !done |=> $stable({flag_high_r, flag_low_r}))
    else $error("conversion without fault moved flags");
  ready_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv |=> ready_r)
    else $error("conversion did not set ready");
  eoc_alert_rdy_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && eoc && alert && !conv && !done |=> $stable(ready_r))
    else $error("alert response moved ready");
  shutdown_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_wr && !run_wr && !conv |=> $stable({flag_high_r, flag_low_r}))
    else $error("shutdown write moved flags");
  eoc_run_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    eoc && run_wr && !conv |=> !int_act_r && !ready_r)
    else $error("run write kept eoc interrupt");
  latch_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    latch && !eoc && run_wr && !pwdata[lsir_pkg::CFG_LATCH_BIT] && !conv |=> !int_act_r)
    else $error("latch drop kept interrupt");
  trans_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    !latch && hf && !lf |=> flag_high_r && !flag_low_r && int_act_r)
    else $error("transparent high fault wrong");
  trans_cfg_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !latch && !eoc && done && !conv |=> $stable({int_act_r, flag_high_r, flag_low_r}))
    else $error("config access moved transparent state");
endmodule // lsir_top
`default_nettype wire

// [test/lsir_host.sv]
// apb host model that drives the block's register bus
`timescale 1ns/1ns
`default_nettype none
module lsir_host (
  // clock
  input wire logic pclk,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer; released address and data lines go inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // lsir_host
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the light sensor interrupt reporting block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, alert_resp;
  logic int_pin, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] conv_result;
  int n_errors = 0;
  int checks_done = 0;

  lsir_top i_lsir_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conv_result(conv_result),
    .alert_resp(alert_resp), .int_pin(int_pin), .irq(irq));
  lsir_host i_lsir_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // 25 mhz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_lsir_host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_lsir_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, exp);
  endtask
  task automatic wcfg(input logic [31:0] d);
    wr(lsir_pkg::ADDR_CONFIG, d);
  endtask
  task automatic rcfg(input logic [31:0] exp);
    rdc(lsir_pkg::ADDR_CONFIG, exp);
  endtask
  // pin is a level, so two edges leave room for its register
  task automatic pin(input logic exp);
    repeat (2) @(posedge pclk);
    chk(32'(int_pin), 32'(exp));
  endtask
  // irq is registered at the completing edge, so look one edge later
  task automatic irqc(input logic exp);
    @(posedge pclk);
    chk(32'(irq), 32'(exp));
  endtask
  task automatic conv(input logic [15:0] v);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask
  task automatic alert();
    @(posedge pclk);
    alert_resp <= 1'b1;
    @(posedge pclk);
    alert_resp <= 1'b0;
  endtask

  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    conv_done = 1'b0;
    alert_resp = 1'b0;
    conv_result = 16'h0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rcfg(32'h0000_0010);
    rdc(lsir_pkg::ADDR_HIGH_LIMIT, 32'h0000_ffff);
    i_lsir_host.xfer(1'b0, 8'h1c, 32'h0000_0000, rd, er);
    chk(32'(er), 32'h0000_0001);
    wr(lsir_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    wr(lsir_pkg::ADDR_LOW_LIMIT, 32'h0000_c000);
    wr(lsir_pkg::ADDR_HIGH_LIMIT, 32'h0000_d000);
    wcfg(32'h0000_0210);
    conv(16'hc800);
    pin(1'b0);
    chk(32'(irq), 32'h0000_0001);
    rcfg(32'h0000_0290);
    pin(1'b1);
    rcfg(32'h0000_0210);
    wr(lsir_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    irqc(1'b0);
    conv(16'he000);
    pin(1'b0);
    alert();
    pin(1'b1);
    rcfg(32'h0000_02d0);
    conv(16'h1000);
    rcfg(32'h0000_02b0);
    conv(16'hc800);
    wcfg(32'h0000_0010);
    pin(1'b0);
    rcfg(32'h0000_0090);
    conv(16'hc800);
    wcfg(32'h0000_0210);
    pin(1'b1);
    rcfg(32'h0000_0210);
    wcfg(32'h0000_0218);
    pin(1'b0);
    conv(16'hc800);
    pin(1'b1);
    rcfg(32'h0000_0298);
    // masked event still lands in status but keeps irq low
    wr(lsir_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    wr(lsir_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    conv(16'hc800);
    rdc(lsir_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
    irqc(1'b0);
    // leave end-of-conversion, then drop the latch bit to free the pin
    wr(lsir_pkg::ADDR_LOW_LIMIT, 32'h0000_0000);
    wcfg(32'h0000_0208);
    pin(1'b0);
    wr(lsir_pkg::ADDR_LOW_LIMIT, 32'h0000_1000);
    wr(lsir_pkg::ADDR_HIGH_LIMIT, 32'h0000_8000);
    wcfg(32'h0000_0201);
    conv(16'h9000);
    pin(1'b1);
    conv(16'h9000);
    pin(1'b0);
    rcfg(32'h0000_02c1);
    alert();
    pin(1'b0);
    conv(16'h0800);
    conv(16'h0800);
    pin(1'b1);
    rcfg(32'h0000_02a1);
    conv(16'h9000);
    conv(16'h4000);
    conv(16'h9000);
    pin(1'b1);
    rcfg(32'h0000_02a1);
    rdc(lsir_pkg::ADDR_RESULT, 32'h0000_9000);
    // injected conversion reuses the last result and completes the high streak
    wr(lsir_pkg::ADDR_EVENT, 32'h0000_0001);
    pin(1'b0);
    rcfg(32'h0000_02c1);
    wr(lsir_pkg::ADDR_EVENT, 32'h0000_0002);
    pin(1'b0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
